// ---- core/pss_regs.sv ----
/*
 * Power control, vector-unit activity and peripheral base locator registers
 * reached through coprocessor read and write instructions.
 * Assumes access requests, context and pins; pins are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Latency field loads from pins after reset.
// - Wait latency after clock cut before driving.
// - Overlong latency still waits full count.
// - Zero latency drives on first wake edge.
// - Gating enable bit zero, resets off.
// - Power control at c15,c0,0 opcode 0.
// - Activity register read-only, writes ignored.
// - Activity bit set while vector work pending.
// - Activity register readable at c15,c1,0.
// - Single-processor build base resets zero.
// - Multiprocessor base resets to supplied bits.
// - Base writable only secure privileged.
// - Power control writable only secure privileged.
module pss_regs
   import pss_pkg::*;
#(
   parameter bit MULTI_CORE = 1'b0,
   parameter logic [18:0] BASE_DEFAULT = PSS_BASE_RST
)(
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Coprocessor access.
   input wire pss_req_s req,
   input wire pss_ctx_s ctx,
   output logic [31:0] rdata,
   output logic rvalid,
   output logic wrDenied,
   // Pins and straps.
   input wire logic [2:0] wakeup_delay_pins,
   input wire logic [18:0] baseStrap,
   // Vector unit status.
   input wire logic vectorBusy,
   // Gated unit side.
   input wire logic unitIdle,
   input wire logic unitReq,
   output logic unitClkOn,
   output logic unitDrive,
   // Visible control state.
   output logic gateEnOut,
   output logic [2:0] latencyOut
);

   logic [2:0] latS1, latS2, latS3; // Latency pin synchroniser.
   logic [2:0] latStable, next_latStable; // Agreed pin value.
   logic [18:0] strapS1, strapS2; // Base strap synchroniser.
   logic capture, next_capture; // High on the first enabled cycle after reset.
   logic gateEn, next_gateEn; // Dynamic gating enable.
   logic [2:0] latency, next_latency; // Wake-up latency field.
   logic [18:0] baseAddr, next_baseAddr; // Peripheral base field.
   logic busyQ, next_busyQ; // Registered vector activity.
   logic [31:0] next_rdata; // Read data.
   logic next_rvalid, next_wrDenied; // Response flags.
   logic hitPower, hitActive, hitBase; // Address decode.
   logic canWrite; // Secure privileged context.

   // Address decode of the coprocessor selector.
   always_comb begin
      hitPower = req.opc1 == PSS_OPC1_MAIN && req.crn == PSS_CRN_C15 &&
                 req.crm == PSS_CRM_C0 && req.opc2 == PSS_OPC2_0;
      hitActive = req.opc1 == PSS_OPC1_MAIN && req.crn == PSS_CRN_C15 &&
                  req.crm == PSS_CRM_C1 && req.opc2 == PSS_OPC2_0;
      hitBase = req.opc1 == PSS_OPC1_BASE && req.crn == PSS_CRN_C15 &&
                req.crm == PSS_CRM_C0 && req.opc2 == PSS_OPC2_0;
      canWrite = ctx.secure && ctx.privileged;
   end

   // Pin synchronisers; the first stages feed only the next stage.
   // The agreed latency value keeps following the pins through reset, so it
   // is already settled when the first cycle after reset captures it.
   always_ff @(posedge sys_clk) begin
      if (clkEn) begin
         latS1 <= wakeup_delay_pins;
         latS2 <= latS1;
         latS3 <= latS2;
         latStable <= next_latStable;
         strapS1 <= baseStrap;
         strapS2 <= strapS1;
      end
   end

   // Next values of the register bank.
   always_comb begin
      next_latStable = latStable;
      if (latS2 == latS3) begin
         next_latStable = latS3;
      end
      next_capture = 1'b0;
      next_gateEn = gateEn;
      next_latency = latency;
      next_baseAddr = baseAddr;
      next_busyQ = vectorBusy;
      next_rdata = rdata;
      next_rvalid = 1'b0;
      next_wrDenied = 1'b0;
      if (capture) begin
         // Leaving reset: take the pin level and, in a multiprocessor build, the base strap.
         next_latency = next_latStable;
         next_baseAddr = MULTI_CORE ? strapS2 : BASE_DEFAULT;
      end else if (req.valid && req.write) begin
         if (hitPower && canWrite) begin
            // Software may rewrite the latency, though it is expected not to.
            next_gateEn = req.wdata[PSS_GATE_EN_BIT];
            next_latency = req.wdata[PSS_LAT_LSB +: PSS_LAT_W];
         end else if (hitBase && canWrite) begin
            next_baseAddr = req.wdata[PSS_BASE_LSB +: PSS_BASE_W];
         end else begin
            // Activity register, denied context or unmapped selector.
            next_wrDenied = 1'b1;
         end
      end else if (req.valid) begin
         next_rvalid = 1'b1;
         next_rdata = 32'h00000000;
         if (hitPower) begin
            next_rdata[PSS_GATE_EN_BIT] = gateEn;
            next_rdata[PSS_LAT_LSB +: PSS_LAT_W] = latency;
         end else if (hitActive) begin
            next_rdata[PSS_ACT_BIT] = busyQ;
         end else if (hitBase) begin
            next_rdata[PSS_BASE_LSB +: PSS_BASE_W] = baseAddr;
         end
      end
   end

   // Register bank flip-flops.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         capture <= 1'b1;
         gateEn <= PSS_GATE_EN_RST;
         latency <= 3'h0;
         baseAddr <= BASE_DEFAULT;
         busyQ <= 1'b0;
         rdata <= 32'h00000000;
         rvalid <= 1'b0;
         wrDenied <= 1'b0;
      end else if (clkEn) begin
         capture <= next_capture;
         gateEn <= next_gateEn;
         latency <= next_latency;
         baseAddr <= next_baseAddr;
         busyQ <= next_busyQ;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         wrDenied <= next_wrDenied;
      end
   end

   // Registered copies of the control fields for the outside.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gateEnOut <= 1'b0;
         latencyOut <= 3'h0;
      end else if (clkEn) begin
         gateEnOut <= gateEn;
         latencyOut <= latency;
      end
   end

   // Clock gate and wake-up delay for the gated unit.
   pss_wake_ctrl u_wake (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .gateEn(gateEn),
      .latency(latency),
      .unitIdle(unitIdle),
      .unitReq(unitReq),
      .unitClkOn(unitClkOn),
      .unitDrive(unitDrive)
   );

endmodule : pss_regs
`default_nettype wire

// ---- core/pss_pkg.sv ----
/*
 * Shared constants and types for the power and status system-coprocessor
 * register bank. Assumes a single processor clock domain.
 */
package pss_pkg;

   // Coprocessor selector fields of the three registers.
   localparam logic [2:0] PSS_OPC1_MAIN = 3'h0;
   localparam logic [2:0] PSS_OPC1_BASE = 3'h4;
   localparam logic [3:0] PSS_CRN_C15 = 4'hF;
   localparam logic [3:0] PSS_CRM_C0 = 4'h0;
   localparam logic [3:0] PSS_CRM_C1 = 4'h1;
   localparam logic [2:0] PSS_OPC2_0 = 3'h0;

   // Power control and activity field layout.
   localparam int PSS_GATE_EN_BIT = 0;
   localparam int PSS_LAT_LSB = 8;
   localparam int PSS_LAT_W = 3;
   localparam int PSS_ACT_BIT = 0;

   // Base address field layout.
   localparam int PSS_BASE_LSB = 13;
   localparam int PSS_BASE_W = 19;

   // Reset values.
   localparam logic PSS_GATE_EN_RST = 1'h0;
   localparam logic [18:0] PSS_BASE_RST = 19'h00000;

   // Idle cycles before a unit's clock is cut when gating is enabled.
   localparam logic [3:0] PSS_IDLE_CUT = 4'h4;

   // One coprocessor access request.
   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] opc1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] opc2;
      logic [31:0] wdata;
   } pss_req_s;

   // Privilege and security context of the access.
   typedef struct packed {
      logic secure;
      logic privileged;
   } pss_ctx_s;

   // Wake-up controller states.
   typedef enum logic [1:0] {
      PSS_RUN,
      PSS_CUT,
      PSS_WAKE
   } pss_gate_e;

endpackage : pss_pkg

// ---- core/pss_wake_ctrl.sv ----
/*
 * Clock gate and wake-up delay controller for one internal unit.
 * Assumes the unit's idle level comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module pss_wake_ctrl
   import pss_pkg::*;
(
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Control.
   input wire logic gateEn,
   input wire logic [2:0] latency,
   input wire logic unitIdle,
   input wire logic unitReq,
   // Unit side.
   output logic unitClkOn,
   output logic unitDrive
);

   pss_gate_e state, next_state; // Controller state.
   logic [3:0] count, next_count; // Idle count or wake-up wait count.
   logic next_clkOn, next_drive; // Next registered outputs.

   // Next-state logic: cut after a short idle spell, then wait the latency on wake.
   always_comb begin
      next_state = state;
      next_count = count;
      next_clkOn = unitClkOn;
      next_drive = unitDrive;
      unique case (state)
         PSS_RUN: begin
            next_clkOn = 1'b1;
            next_drive = 1'b1;
            if (gateEn && unitIdle && !unitReq) begin
               if (count == PSS_IDLE_CUT) begin
                  next_state = PSS_CUT;
                  next_clkOn = 1'b0;
                  next_drive = 1'b0;
                  next_count = 4'h0;
               end else begin
                  next_count = count + 4'h1;
               end
            end else begin
               next_count = 4'h0;
            end
         end
         PSS_CUT: begin
            // Restart the clock but hold signals off for the programmed delay.
            if (unitReq || !gateEn) begin
               next_clkOn = 1'b1;
               next_count = {1'b0, latency};
               if (latency == 3'h0) begin
                  next_state = PSS_RUN;
                  next_drive = 1'b1;
               end else begin
                  next_state = PSS_WAKE;
               end
            end
         end
         PSS_WAKE: begin
            // Full programmed count is always honoured, even if too long.
            if (count == 4'h1) begin
               next_state = PSS_RUN;
               next_drive = 1'b1;
               next_count = 4'h0;
            end else begin
               next_count = count - 4'h1;
            end
         end
         default: begin
            // An illegal code falls back to the running state.
            next_state = PSS_RUN;
         end
      endcase
   end

   // State registers.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= PSS_RUN;
         count <= 4'h0;
         unitClkOn <= 1'b1;
         unitDrive <= 1'b1;
      end else if (clkEn) begin
         state <= next_state;
         count <= next_count;
         unitClkOn <= next_clkOn;
         unitDrive <= next_drive;
      end
   end

endmodule : pss_wake_ctrl
`default_nettype wire

// ---- tb/pss_regs_props.sv ----
/* Assertion checker for the power and status register bank.
   Assumes it is bound to pss_regs and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none
module pss_regs_props
   import pss_pkg::*;
(
   // Clock, reset and coprocessor access.
   input wire logic sys_clk, input wire logic rst, input wire logic clkEn,
   input wire pss_req_s req, input wire pss_ctx_s ctx,
   input wire logic [31:0] rdata, input wire logic rvalid, input wire logic wrDenied,
   // Pins, status and gated unit.
   input wire logic [2:0] wakeup_delay_pins, input wire logic [18:0] baseStrap,
   input wire logic vectorBusy, input wire logic unitIdle, input wire logic unitReq,
   input wire logic unitClkOn, input wire logic unitDrive,
   input wire logic gateEnOut, input wire logic [2:0] latencyOut
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Which register a request selects.
   wire isPwr = req.crn == PSS_CRN_C15 && req.opc1 == PSS_OPC1_MAIN && req.crm == PSS_CRM_C0
      && req.opc2 == PSS_OPC2_0;
   wire isAct = req.crn == PSS_CRN_C15 && req.opc1 == PSS_OPC1_MAIN && req.crm == PSS_CRM_C1
      && req.opc2 == PSS_OPC2_0;
   wire isBase = req.crn == PSS_CRN_C15 && req.opc1 == PSS_OPC1_BASE && req.crm == PSS_CRM_C0
      && req.opc2 == PSS_OPC2_0;
   // Cycles the unit clock has run while driving is still held off.
   logic [3:0] waitCnt;
   logic [3:0] next_waitCnt;
   // Clears while the clock is cut and counts until driving resumes.
   always_comb begin
      if (!unitClkOn) begin
         next_waitCnt = 4'h0;
      end else if (!unitDrive && waitCnt != 4'hF) begin
         next_waitCnt = waitCnt + 4'h1;
      end else begin
         next_waitCnt = waitCnt;
      end
   end
   // Registers the counter.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         waitCnt <= 4'h0;
      end else begin
         waitCnt <= next_waitCnt;
      end
   end
   // A request taken by the bank, outside the capture cycle after reset.
   sequence s_take(logic wr);
      req.valid && req.write == wr && clkEn && !$past(rst);
   endsequence
   property p_rd_ans; s_take(1'b0) |=> rvalid && !wrDenied; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
   property p_act_ro; s_take(1'b1) ##0 isAct |=> wrDenied && !rvalid; endproperty
   a_act_ro: assert property (p_act_ro) else $error("activity write not refused");
   property p_ctx; s_take(1'b1) ##0 !(ctx.secure && ctx.privileged) |=> wrDenied; endproperty
   a_ctx: assert property (p_ctx) else $error("write context not refused");
   property p_pwr_rsvd;
      s_take(1'b0) ##0 isPwr |=> rdata[31:11] == 21'h0 && rdata[7:1] == 7'h0;
   endproperty
   a_pwr_rsvd: assert property (p_pwr_rsvd) else $error("power reserved bits set");
   property p_act_bit;
      s_take(1'b0) ##0 isAct |=> rdata[31:1] == 31'h0 && rdata[0] == $past(vectorBusy, 2);
   endproperty
   a_act_bit: assert property (p_act_bit) else $error("activity bit wrong");
   property p_base_rsvd; s_take(1'b0) ##0 isBase |=> rdata[12:0] == 13'h0; endproperty
   a_base_rsvd: assert property (p_base_rsvd) else $error("base low bits set");
   property p_unmap; s_take(1'b0) ##0 !(isPwr || isAct || isBase) |=> rdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_cut_drive; !unitClkOn |-> !unitDrive; endproperty
   a_cut_drive: assert property (p_cut_drive) else $error("drive while cut");
   property p_wake; $rose(unitDrive) |-> unitClkOn && waitCnt == {1'b0, latencyOut}; endproperty
   a_wake: assert property (p_wake) else $error("wake delay wrong");
   property p_cut_gate; $fell(unitClkOn) |-> $past(gateEnOut) && !unitDrive; endproperty
   a_cut_gate: assert property (p_cut_gate) else $error("cut without gating");
   property p_busy_run;
      (unitReq || !unitIdle) && unitDrive |=> unitClkOn && unitDrive;
   endproperty
   a_busy_run: assert property (p_busy_run) else $error("busy unit lost its clock");
   property p_cap_lat; $past(rst) |-> ##2 latencyOut == wakeup_delay_pins; endproperty
   a_cap_lat: assert property (p_cap_lat) else $error("latency not taken from pins");
endmodule : pss_regs_props
bind pss_regs pss_regs_props u_props (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
   .req(req), .ctx(ctx), .rdata(rdata), .rvalid(rvalid), .wrDenied(wrDenied),
   .wakeup_delay_pins(wakeup_delay_pins), .baseStrap(baseStrap), .vectorBusy(vectorBusy),
   .unitIdle(unitIdle), .unitReq(unitReq), .unitClkOn(unitClkOn), .unitDrive(unitDrive),
   .gateEnOut(gateEnOut), .latencyOut(latencyOut));
`default_nettype wire

// ---- tb/pss_regs_tb_top.sv ----
/* Self-checking bench for the power and status register bank.
   Assumes the checker is bound in; inputs change at falling edges. */
`timescale 1ns/1ns
`default_nettype none
module pss_regs_tb_top;
   import pss_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, rvalid, wrDenied, unitClkOn, unitDrive, gateEnOut;
   logic vectorBusy = 1'b0, unitIdle = 1'b0, unitReq = 1'b0;
   logic [2:0] latencyOut;
   logic [2:0] pins;
   logic [31:0] rdataSc;
   logic [2:0] lats [3] = '{3'h0, 3'h2, 3'h7};
   logic [18:0] strap;
   logic [31:0] rdata, d;
   logic [32:0] e;
   logic [32:0] expQ [$];
   pss_req_s req = '0;
   pss_ctx_s ctx = '0;
   int n_fail = 0, n_checks = 0, k;
   // Free-running system clock.
   always #5 sys_clk = ~sys_clk;
   pss_regs #(.MULTI_CORE(1'b1)) DUT (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .req(req),
      .ctx(ctx), .rdata(rdata), .rvalid(rvalid), .wrDenied(wrDenied),
      .wakeup_delay_pins(pins), .baseStrap(strap), .vectorBusy(vectorBusy),
      .unitIdle(unitIdle), .unitReq(unitReq), .unitClkOn(unitClkOn), .unitDrive(unitDrive),
      .gateEnOut(gateEnOut), .latencyOut(latencyOut));
   // Single-processor build on the same stimulus, for its base reset value.
   pss_regs #(.MULTI_CORE(1'b0)) DUT_SC (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1),
      .req(req), .ctx(ctx), .rdata(rdataSc), .rvalid(), .wrDenied(),
      .wakeup_delay_pins(pins), .baseStrap(strap), .vectorBusy(vectorBusy),
      .unitIdle(unitIdle), .unitReq(unitReq), .unitClkOn(), .unitDrive(),
      .gateEnOut(), .latencyOut());
   // Compares one observed value with its expectation.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Issues one access as a one-cycle request pulse.
   task automatic acc(input logic wr, input logic [2:0] o1, input logic [3:0] m,
         input logic [31:0] wd, input logic [1:0] sp);
      @(negedge sys_clk);
      req = '{1'b1, wr, o1, PSS_CRN_C15, m, PSS_OPC2_0, wd};
      ctx = sp;
      @(negedge sys_clk);
      req.valid = 1'b0;
   endtask : acc
   // Reads a register and notes the expected data.
   task automatic rd(input logic [2:0] o1, input logic [3:0] m, input logic [31:0] exp);
      expQ.push_back({1'b0, exp});
      acc(1'b0, o1, m, 32'h0, 2'b11);
   endtask : rd
   // Writes a register and notes a refusal where one is due.
   task automatic wr(input logic [2:0] o1, input logic [3:0] m, input logic [31:0] wd,
         input logic [1:0] sp, input logic deny);
      if (deny) expQ.push_back(33'h1_0000_0000);
      acc(1'b1, o1, m, wd, sp);
   endtask : wr
   // Matches each answer against the oldest note.
   always @(posedge sys_clk) begin
      #1;
      if (rvalid === 1'b1 || wrDenied === 1'b1) begin
         chk(32'(expQ.size() > 0), 32'h1);
         e = (expQ.size() > 0) ? expQ.pop_front() : 33'h0;
         chk({31'h0, wrDenied}, {31'h0, e[32]});
         chk({31'h0, rvalid}, {31'h0, ~e[32]});
         if (!e[32]) chk(rdata, e[31:0]);
      end
   end
   // Prints the counts and the verdict, then stops.
   task automatic complete_run;
      $display("Checks %0d, failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   // Cuts a hang short.
   initial begin
      #50000;
      n_fail++;
      complete_run();
   end
   // Main sequence of scenarios.
   initial begin
      void'($urandom(32'h5450B985));
      strap = 19'($urandom);
      pins = 3'($urandom);
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      rd(PSS_OPC1_MAIN, PSS_CRM_C0, {21'h0, pins, 8'h00});
      chk({28'h0, gateEnOut, latencyOut}, {28'h0, 1'b0, pins});
      rd(PSS_OPC1_BASE, PSS_CRM_C0, {strap, 13'h0});
      chk(rdataSc, 32'h0);
      d = $urandom;
      wr(PSS_OPC1_MAIN, PSS_CRM_C0, d, 2'b11, 1'b0);
      rd(PSS_OPC1_MAIN, PSS_CRM_C0, {21'h0, d[10:8], 7'h0, d[0]});
      chk({28'h0, gateEnOut, latencyOut}, {28'h0, d[0], d[10:8]});
      wr(PSS_OPC1_MAIN, PSS_CRM_C0, ~d, 2'b01, 1'b1);
      wr(PSS_OPC1_MAIN, PSS_CRM_C0, ~d, 2'b10, 1'b1);
      rd(PSS_OPC1_MAIN, PSS_CRM_C0, {21'h0, d[10:8], 7'h0, d[0]});
      wr(PSS_OPC1_BASE, PSS_CRM_C0, d, 2'b11, 1'b0);
      wr(PSS_OPC1_BASE, PSS_CRM_C0, ~d, 2'b01, 1'b1);
      wr(PSS_OPC1_BASE, PSS_CRM_C0, ~d, 2'b10, 1'b1);
      rd(PSS_OPC1_BASE, PSS_CRM_C0, {d[31:13], 13'h0});
      wr(PSS_OPC1_MAIN, PSS_CRM_C1, d, 2'b11, 1'b1);
      for (k = 0; k < 2; k++) begin
         vectorBusy = k[0];
         repeat (2) @(negedge sys_clk);
         rd(PSS_OPC1_MAIN, PSS_CRM_C1, {31'h0, k[0]});
      end
      rd(PSS_OPC1_MAIN, 4'h7, 32'h0);
      wr(PSS_OPC1_MAIN, 4'h7, d, 2'b11, 1'b1);
      unitIdle = 1'b1;
      wr(PSS_OPC1_MAIN, PSS_CRM_C0, 32'h0, 2'b11, 1'b0);
      repeat (10) @(negedge sys_clk);
      chk({31'h0, unitClkOn}, 32'h1);
      foreach (lats[i]) begin
         wr(PSS_OPC1_MAIN, PSS_CRM_C0, {21'h0, lats[i], 8'h01}, 2'b11, 1'b0);
         repeat (10) @(negedge sys_clk);
         chk({30'h0, unitClkOn, unitDrive}, 32'h0);
         unitReq = 1'b1;
         k = 0;
         do begin
            @(negedge sys_clk);
            k++;
         end while (unitDrive !== 1'b1 && k < 20);
         chk(32'(k), 32'(lats[i]) + 32'h1);
         unitReq = 1'b0;
      end
      unitIdle = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(32'(expQ.size()), 32'h0);
      complete_run();
   end
endmodule : pss_regs_tb_top
`default_nettype wire
